// file: core/rpm_sequencer.sv
`timescale 1ns/100ps

module rpm_sequencer
  import rpm_pkg::*;
#(
  parameter int PSENSE_CYCLES = RPM_PSENSE_MAX_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      por_done,
  input  wire logic                      system_supply_sense,
  input  wire logic                      line_in_window,
  input  wire logic                      clock_source,
  input  wire logic                      second_tick,
  input  wire logic                      alarm_match,
  input  wire logic                      periodic_tick,
  input  wire logic                      read_active,
  input  wire logic                      reg_rd,
  input  wire logic                      reg_wr,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           buffered_clock_output,
  output logic                           supply_enable_output,
  output logic                           processor_reset_output,
  output logic                           serial_io_enable,
  output logic                           slave_select_enable,
  output logic                           counter_advance,
  output logic                           interrupt_n,
  output logic                           single_supply_mode,
  output logic      [7:0]                clock_control,
  output logic      [RPM_PERIODIC_W-1:0] periodic_select
);

  // ==========================================================================
  // Decode helper.
  // ==========================================================================
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================================
  // Input synchronisation.
  // ==========================================================================
  logic [1:0] pin_sync;
  logic       supply_s;
  logic       line_s;

  rpm_sync3 #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({line_in_window, system_supply_sense}),
    .sync_out (pin_sync)
  );

  assign supply_s = pin_sync[0];
  assign line_s   = pin_sync[1];

  // ==========================================================================
  // State and registers.
  // ==========================================================================
  rpm_state_type                 state_q;
  rpm_state_type                 state_d;
  logic                          single_q;
  logic                          supply_prev_q;
  logic                          seen_low_q;
  logic [7:0]                    clk_ctrl_q;
  logic [7:0]                    int_ctrl_q;
  logic                          flag_periodic_q;
  logic                          flag_alarm_q;
  logic                          flag_int_true_q;
  logic                          alarm_pending_q;
  logic                          line_prev_q;
  logic [RPM_PSENSE_CNT_W-1:0]   psense_cnt_q;
  logic [7:0]                    rdata_q;
  logic                          buffered_clock_output_q;
  logic                          pse_q;
  logic                          processor_reset_output_q;
  logic                          sio_en_q;
  logic                          ss_en_q;
  logic                          advance_q;
  logic                          int_n_q;

  logic access_ok;
  logic wr_int_ctrl;
  logic rd_status;
  logic supply_rise;
  logic alarm_event;
  logic wake_irq;
  logic wake;
  logic psense_done;

  localparam logic [RPM_PSENSE_CNT_W-1:0] PSENSE_LAST =
    RPM_PSENSE_CNT_W'(PSENSE_CYCLES - 1);

  // Serial access is only honoured while fully operational.
  assign access_ok   = (state_q == RPM_ST_RUN);
  assign wr_int_ctrl = access_ok && reg_wr &&
                       hit(reg_addr, RPM_ADDR_INT_CTRL_WR);
  assign rd_status   = access_ok && reg_rd &&
                       hit(reg_addr, RPM_ADDR_STATUS_RD);
  assign supply_rise = supply_s && !supply_prev_q;

  // An alarm seen during a read is held and signalled once the read ends.
  assign alarm_event = !read_active &&
                       (alarm_match || alarm_pending_q);

  assign wake_irq = (int_ctrl_q[RPM_IC_ALARM_BIT] && flag_alarm_q) ||
                    (int_ctrl_q[RPM_IC_PERIODIC_MSB:RPM_IC_PERIODIC_LSB]
                     != '0 && flag_periodic_q);
  assign wake     = supply_s &&
                    (wake_irq || (seen_low_q && supply_rise));

  assign psense_done = int_ctrl_q[RPM_IC_PSENSE_BIT] && line_s &&
                       (line_s == line_prev_q) &&
                       (psense_cnt_q == PSENSE_LAST);

  // ==========================================================================
  // Power-mode sequencer.
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      RPM_ST_POR: begin
        if (por_done) begin
          state_d = supply_s ? RPM_ST_RUN : RPM_ST_BATT_WAIT;
        end
      end
      RPM_ST_RUN: begin
        if (!single_q && !supply_s) begin
          state_d = RPM_ST_BATT_WAIT;
        end else if (wr_int_ctrl && reg_wdata[RPM_IC_PDOWN_BIT]) begin
          state_d = RPM_ST_PDOWN;
        end
      end
      RPM_ST_BATT_WAIT: begin
        if (supply_s) begin
          state_d = RPM_ST_RUN;
        end
      end
      RPM_ST_PDOWN: begin
        if (wake) begin
          state_d = RPM_ST_RUN;
        end
      end
      default: begin
        state_d = RPM_ST_POR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= RPM_ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Mode is caught at the end of power-on reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_q <= 1'b0;
    end else if (state_q == RPM_ST_POR && por_done) begin
      single_q <= supply_s;
    end
  end

  // Supply loss during power-down, either seen directly or by power sense.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_prev_q <= 1'b0;
      seen_low_q    <= 1'b0;
    end else begin
      supply_prev_q <= supply_s;
      if (state_q != RPM_ST_PDOWN) begin
        seen_low_q <= 1'b0;
      end else if (!supply_s || flag_int_true_q) begin
        seen_low_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_ctrl_q <= RPM_CLK_CTRL_RST;
    end else if (access_ok && reg_wr &&
                 hit(reg_addr, RPM_ADDR_CLK_CTRL_WR)) begin
      clk_ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_ctrl_q <= RPM_INT_CTRL_RST;
    end else if (wr_int_ctrl) begin
      int_ctrl_q <= reg_wdata;
    end else if (state_q == RPM_ST_PDOWN && wake) begin
      int_ctrl_q[RPM_IC_PDOWN_BIT] <= 1'b0;
    end
  end

  // ==========================================================================
  // Status flags; a new event wins over the clearing read.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_pending_q <= 1'b0;
    end else if (!read_active) begin
      alarm_pending_q <= 1'b0;
    end else if (alarm_match) begin
      alarm_pending_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_alarm_q    <= 1'b0;
      flag_periodic_q <= 1'b0;
      flag_int_true_q <= 1'b0;
    end else begin
      if (alarm_event) begin
        flag_alarm_q <= 1'b1;
      end else if (rd_status) begin
        flag_alarm_q <= 1'b0;
      end
      if (periodic_tick) begin
        flag_periodic_q <= 1'b1;
      end else if (rd_status) begin
        flag_periodic_q <= 1'b0;
      end
      if (psense_done) begin
        flag_int_true_q <= 1'b1;
      end else if (rd_status) begin
        flag_int_true_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Line-input power sensing.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_prev_q  <= 1'b0;
      psense_cnt_q <= '0;
    end else begin
      line_prev_q <= line_s;
      if (!int_ctrl_q[RPM_IC_PSENSE_BIT]) begin
        psense_cnt_q <= '0;
      end else if (!line_s || line_s != line_prev_q) begin
        psense_cnt_q <= '0;
      end else if (psense_cnt_q != PSENSE_LAST) begin
        psense_cnt_q <= psense_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Register read data.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (access_ok && reg_rd) begin
      rdata_q <= 8'h00;
      case (reg_addr)
        RPM_ADDR_STATUS_RD: begin
          rdata_q[RPM_ST_PERIODIC_BIT] <= flag_periodic_q;
          rdata_q[RPM_ST_ALARM_BIT]    <= flag_alarm_q;
          rdata_q[RPM_ST_INT_TRUE_BIT] <= flag_int_true_q;
        end
        RPM_ADDR_CLK_CTRL_RD: begin
          rdata_q <= clk_ctrl_q;
        end
        RPM_ADDR_INT_CTRL_RD: begin
          rdata_q <= int_ctrl_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Output gating.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buffered_clock_output_q <= 1'b0;
      pse_q    <= 1'b0;
      processor_reset_output_q   <= 1'b0;
    end else if (state_d == RPM_ST_RUN) begin
      buffered_clock_output_q <= clock_source;
      pse_q    <= 1'b1;
      processor_reset_output_q   <= supply_s;
    end else begin
      buffered_clock_output_q <= 1'b0;
      pse_q    <= 1'b0;
      processor_reset_output_q   <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sio_en_q <= 1'b0;
      ss_en_q  <= 1'b0;
    end else begin
      sio_en_q <= (state_d == RPM_ST_RUN);
      ss_en_q  <= (state_d == RPM_ST_RUN) ||
                  (state_d == RPM_ST_PDOWN);
    end
  end

  // The counters lose the tick rather than catch up after a read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      advance_q <= 1'b0;
    end else begin
      advance_q <= second_tick && !read_active;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= !(wake_irq || flag_int_true_q);
    end
  end

  assign reg_rdata              = rdata_q;
  assign buffered_clock_output  = buffered_clock_output_q;
  assign supply_enable_output   = pse_q;
  assign processor_reset_output = processor_reset_output_q;
  assign serial_io_enable       = sio_en_q;
  assign slave_select_enable    = ss_en_q;
  assign counter_advance        = advance_q;
  assign interrupt_n            = int_n_q;
  assign single_supply_mode     = single_q;
  assign clock_control          = clk_ctrl_q;
  assign periodic_select        =
    int_ctrl_q[RPM_IC_PERIODIC_MSB:RPM_IC_PERIODIC_LSB];

endmodule

// file: core/rpm_sync3.sv
`timescale 1ns/100ps

// ============================================================================
// Three-stage synchroniser; a change is taken once stages two and three agree.
// ============================================================================
module rpm_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sync_out = out_q;

endmodule

// file: inc/rpm_pkg.sv
package rpm_pkg;

  // ==========================================================================
  // Register addresses as seen by the serial engine.
  // ==========================================================================
  localparam logic [7:0] RPM_ADDR_STATUS_RD   = 8'h30;
  localparam logic [7:0] RPM_ADDR_CLK_CTRL_RD = 8'h31;
  localparam logic [7:0] RPM_ADDR_INT_CTRL_RD = 8'h32;
  localparam logic [7:0] RPM_ADDR_CLK_CTRL_WR = 8'hb1;
  localparam logic [7:0] RPM_ADDR_INT_CTRL_WR = 8'hb2;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0] RPM_CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] RPM_INT_CTRL_RST = 8'h00;

  // ==========================================================================
  // Interrupt control field positions.
  // ==========================================================================
  localparam int RPM_IC_WATCHDOG_BIT  = 7;
  localparam int RPM_IC_PDOWN_BIT     = 6;
  localparam int RPM_IC_PSENSE_BIT    = 5;
  localparam int RPM_IC_ALARM_BIT     = 4;
  localparam int RPM_IC_PERIODIC_MSB  = 3;
  localparam int RPM_IC_PERIODIC_LSB  = 0;
  localparam int RPM_PERIODIC_W       = 4;

  // ==========================================================================
  // Status field positions.
  // ==========================================================================
  localparam int RPM_ST_PERIODIC_BIT  = 0;
  localparam int RPM_ST_ALARM_BIT     = 1;
  localparam int RPM_ST_INT_TRUE_BIT  = 2;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int RPM_CLK_MHZ          = 200;
  localparam int RPM_PSENSE_MIN_US    = 2680;
  localparam int RPM_PSENSE_MAX_US    = 4640;
  localparam int RPM_PSENSE_MAX_CYC   = RPM_PSENSE_MAX_US * RPM_CLK_MHZ;
  localparam int RPM_PSENSE_CNT_W     = 20;

  // ==========================================================================
  // Sequencer states.
  // ==========================================================================
  typedef enum logic [1:0] {
    RPM_ST_POR,
    RPM_ST_RUN,
    RPM_ST_BATT_WAIT,
    RPM_ST_PDOWN
  } rpm_state_type;

endpackage

// file: verif/rpm_host_env.sv
`timescale 1ns/100ps

// ============================================================================
// Supply rail, mains line and oscillator as the sequencer sees them.
// ============================================================================
module rpm_host_env (
  input  wire logic clk,
  input  wire logic supply_on,
  input  wire logic line_ac,
  output logic      system_supply_sense,
  output logic      line_in_window,
  output logic      clock_source
);
  logic [2:0] ph_q;

  initial begin
    ph_q = 3'h0;
    system_supply_sense = 1'b1;
    line_in_window = 1'b1;
    clock_source = 1'b0;
  end

  always @(posedge clk) begin
    system_supply_sense <= supply_on;
    clock_source <= ~clock_source;
  end

  // A live mains wave leaves the window every few cycles; a dead one is
  // pulled inside it and stays there.
  always @(posedge clk) begin
    ph_q <= (ph_q == 3'h6) ? 3'h0 : ph_q + 3'h1;
    if (!line_ac) begin
      line_in_window <= 1'b1;
    end else if (ph_q == 3'h6) begin
      line_in_window <= ~line_in_window;
    end
  end
endmodule

// file: verif/rpm_sequencer_properties.sv
`timescale 1ns/100ps

// ============================================================================
// Port checks of the power sequencer.
// ============================================================================
module rpm_sequencer_properties (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       system_supply_sense,
  input wire logic       clock_source,
  input wire logic       second_tick,
  input wire logic       periodic_tick,
  input wire logic       read_active,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       buffered_clock_output,
  input wire logic       supply_enable_output,
  input wire logic       processor_reset_output,
  input wire logic       serial_io_enable,
  input wire logic       counter_advance,
  input wire logic       interrupt_n,
  input wire logic       single_supply_mode
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  pdown_outs_a: assert property (
    reg_wr && reg_addr == 8'hb2 && reg_wdata[6] && serial_io_enable |->
    ##[1:2] !(supply_enable_output || buffered_clock_output ||
    processor_reset_output || serial_io_enable))
    else $error("outputs stay up after power-down write");
  freeze_cnt_a: assert property (
    second_tick && read_active |=> !counter_advance)
    else $error("counter advanced during a read");
  alarm_hold_a: assert property (
    (read_active && interrupt_n && !periodic_tick)[*2] |=> interrupt_n)
    else $error("interrupt raised during a read");
  out_rise_a: assert property (
    $rose(supply_enable_output) |-> processor_reset_output &&
    serial_io_enable)
    else $error("outputs did not come up together");
  batt_fall_a: assert property (
    !single_supply_mode && $fell(processor_reset_output) |->
    !supply_enable_output && !buffered_clock_output)
    else $error("battery mode outputs not all low");
  single_processor_reset_output_a: assert property (
    single_supply_mode && serial_io_enable && $fell(system_supply_sense)
    |-> ##[1:7] !processor_reset_output)
    else $error("processor reset missing on supply drop");
  mode_hold_a: assert property (
    single_supply_mode |=> single_supply_mode)
    else $error("supply mode changed without reset");
  sync_delay_a: assert property (
    !single_supply_mode && !supply_enable_output &&
    $rose(system_supply_sense) |=> !supply_enable_output ##[1:5]
    supply_enable_output)
    else $error("supply return not taken after sync");
  clk_follow_a: assert property (
    supply_enable_output && $past(supply_enable_output) |->
    buffered_clock_output == $past(clock_source))
    else $error("clock output does not follow source");

  pdown_c: cover property (!serial_io_enable && !processor_reset_output);
  wake_c: cover property ($rose(serial_io_enable));
  int_c: cover property ($fell(interrupt_n));
endmodule

bind rpm_sequencer rpm_sequencer_properties chk_u (
  .clk, .sys_rst, .system_supply_sense, .clock_source, .second_tick,
  .periodic_tick, .read_active, .reg_wr, .reg_addr, .reg_wdata,
  .buffered_clock_output, .supply_enable_output, .processor_reset_output,
  .serial_io_enable, .counter_advance, .interrupt_n, .single_supply_mode
);

// file: verif/tb.sv
`timescale 1ns/100ps

module tb;
  import rpm_pkg::*;
  localparam int PS = 20;
  logic       clk, sys_rst, por_done, supply_on, line_ac;
  logic       system_supply_sense, line_in_window, clock_source;
  logic       second_tick, alarm_match, periodic_tick, read_active;
  logic       reg_rd, reg_wr, buffered_clock_output;
  logic       supply_enable_output, processor_reset_output;
  logic       serial_io_enable, slave_select_enable, counter_advance;
  logic       interrupt_n, single_supply_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, clock_control;
  logic [3:0] periodic_select;
  int         miscompares, compares;

  rpm_host_env env_u (.clk, .supply_on, .line_ac, .system_supply_sense,
    .line_in_window, .clock_source);
  rpm_sequencer #(.PSENSE_CYCLES(PS)) dut_u (.clk, .sys_rst, .por_done,
    .system_supply_sense, .line_in_window, .clock_source, .second_tick,
    .alarm_match, .periodic_tick, .read_active, .reg_rd, .reg_wr,
    .reg_addr, .reg_wdata, .reg_rdata, .buffered_clock_output,
    .supply_enable_output, .processor_reset_output, .serial_io_enable,
    .slave_select_enable, .counter_advance, .interrupt_n,
    .single_supply_mode, .clock_control, .periodic_select);

  // ==========================================================================
  // Bus cycles and comparisons.
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    second_tick <= (k == 0);
    alarm_match <= (k == 1);
    periodic_tick <= (k == 2);
    @(posedge clk);
    {second_tick, alarm_match, periodic_tick} <= 3'h0;
    #1;
  endtask
  task automatic supply(input logic v, input int n);
    @(posedge clk);
    supply_on <= v;
    tick(n);
  endtask
  task automatic boot(input logic v);
    supply(v, 0);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    por_done <= 1'b1;
    @(posedge clk);
    por_done <= 1'b0;
    tick(3);
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence.
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    {sys_rst, por_done, supply_on, line_ac} = 4'hb;
    {second_tick, alarm_match, periodic_tick, read_active} = 4'h0;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h0;
    boot(1'b1);
    chk1(single_supply_mode, 1'b1);
    chk1(supply_enable_output & processor_reset_output, 1'b1);
    rd(RPM_ADDR_CLK_CTRL_RD, RPM_CLK_CTRL_RST);
    rd(RPM_ADDR_INT_CTRL_RD, RPM_INT_CTRL_RST);
    rd(8'h33, 8'h00);
    wr(8'hb1, 8'h5a);
    rd(8'h31, 8'h5a);
    chk8(clock_control, 8'h5a);
    @(posedge clk);
    read_active <= 1'b1;
    pulse(0);
    chk1(counter_advance, 1'b0);
    wr(8'hb2, 8'h10);
    pulse(1);
    tick(4);
    chk1(interrupt_n, 1'b1);
    @(posedge clk);
    read_active <= 1'b0;
    tick(3);
    chk1(interrupt_n, 1'b0);
    pulse(0);
    chk1(counter_advance, 1'b1);
    rd(8'h30, 8'h02);
    rd(8'h30, 8'h00);
    supply(1'b0, 10);
    chk1(processor_reset_output, 1'b0);
    chk1(supply_enable_output, 1'b1);
    supply(1'b1, 10);
    wr(8'hb2, 8'h00);
    tick(PS + 10);
    rd(8'h30, 8'h00);
    wr(8'hb2, 8'h20);
    line_ac <= 1'b1;
    tick(3 * PS);
    rd(8'h30, 8'h00);
    while (line_in_window !== 1'b0) @(posedge clk);
    line_ac <= 1'b0;
    tick(PS - 3);
    rd(8'h30, 8'h00);
    tick(12);
    chk1(interrupt_n, 1'b0);
    line_ac <= 1'b1;
    tick(16);
    rd(8'h30, 8'h04);
    rd(8'h30, 8'h00);
    wr(8'hb2, 8'h60);
    tick(12);
    chk1(supply_enable_output | processor_reset_output, 1'b0);
    chk1(buffered_clock_output | serial_io_enable, 1'b0);
    supply(1'b0, 8);
    supply(1'b1, 10);
    chk1(processor_reset_output & serial_io_enable, 1'b1);
    chk1(interrupt_n, 1'b1);
    rd(8'h32, 8'h20);
    wr(8'hb2, 8'h50);
    tick(4);
    pulse(1);
    tick(6);
    chk1(supply_enable_output & processor_reset_output, 1'b1);
    rd(8'h30, 8'h02);
    wr(8'hb2, 8'h41);
    tick(4);
    pulse(2);
    tick(6);
    chk1(supply_enable_output & processor_reset_output, 1'b1);
    rd(8'h30, 8'h01);
    chk8({4'h0, periodic_select}, 8'h01);
    boot(1'b0);
    tick(10);
    chk1(single_supply_mode, 1'b0);
    chk1(supply_enable_output | slave_select_enable, 1'b0);
    supply(1'b1, 10);
    chk1(supply_enable_output & processor_reset_output, 1'b1);
    supply(1'b0, 10);
    chk1(supply_enable_output | buffered_clock_output, 1'b0);
    supply(1'b1, 10);
    chk1(processor_reset_output & interrupt_n, 1'b1);
    close_out();
  end
endmodule
